// [design/adc_source_reference_select.sv]
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps
module adc_source_reference_select (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic nrst_in,
   // Register port
   input wire logic [1:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   // External channel select from the neighbouring register
   input wire logic [3:0] external_channel_sel_in,
   // Analog controls
   output adc_ctrl_pkg::analog_ctl_t analog_ctl_out,
   output logic [3:0] external_channel_sel_out,
   output logic conv_clk_out
);
   import adc_ctrl_pkg::*;

   logic [7:0] sel_ff;
   logic [7:0] refctl_ff;
   logic [7:0] bg_ff;
   logic [7:0] rdata_ff;
   analog_ctl_t ctl_ff;
   analog_ctl_t nxt_ctl;
   logic [3:0] chan_ff;
   logic [3:0] src;
   logic [1:0] refsel;

   // Register a byte through its implemented mask
   function automatic logic [7:0] masked(input logic [7:0] d, input logic [7:0] m);
      masked = d & m;
   endfunction : masked

   // Register writes
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sel_ff <= REG_RESET;
         refctl_ff <= REG_RESET;
         bg_ff <= REG_RESET;
      end else if (wr_in) begin
         if (addr_in == ADC_INPUT_AND_CLOCK_SELECT_OFS) begin
            sel_ff <= masked(wdata_in, SEL_MASK);
         end else if (addr_in == ADC_REFERENCE_AND_AMP_CONTROL_OFS) begin
            refctl_ff <= masked(wdata_in, REFCTL_MASK);
         end else if (addr_in == BANDGAP_CONTROL_OFS) begin
            bg_ff <= masked(wdata_in, BG_MASK);
         end
      end
   end

   // Read data, valid the cycle after the strobe; unmapped reads zero
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rdata_ff <= 8'h00;
      end else if (rd_in) begin
         if (addr_in == ADC_INPUT_AND_CLOCK_SELECT_OFS) begin
            rdata_ff <= sel_ff;
         end else if (addr_in == ADC_REFERENCE_AND_AMP_CONTROL_OFS) begin
            rdata_ff <= refctl_ff;
         end else if (addr_in == BANDGAP_CONTROL_OFS) begin
            rdata_ff <= bg_ff;
         end else begin
            rdata_ff <= 8'h00;
         end
      end else begin
         rdata_ff <= 8'h00;
      end
   end

   assign src = sel_ff[SRC_LSB +: 4];
   assign refsel = refctl_ff[REF_LSB +: 2];

   // Decode the analog switch settings
   always_comb begin
      nxt_ctl = '0;
      case (src)
         4'h1, 4'h2, 4'h3: begin
            nxt_ctl.route = IN_SUPPLY;
            nxt_ctl.fraction = src[1:0] - 2'h1;
         end
         4'h5, 4'h6, 4'h7: begin
            nxt_ctl.route = IN_AMP;
            nxt_ctl.fraction = src[1:0] - 2'h1;
         end
         4'h8, 4'h9, 4'ha, 4'hb: begin
            nxt_ctl.route = IN_GROUND;
         end
         default: begin
            nxt_ctl.route = IN_EXTERNAL;
            nxt_ctl.ext_channel_on = 1'b1;
         end
      endcase
      // External path only for external route
      if (nxt_ctl.route != IN_EXTERNAL) begin
         nxt_ctl.ext_channel_on = 1'b0;
      end
      case (refsel)
         2'h0: nxt_ctl.ref_route = REF_SUPPLY;
         2'h1: nxt_ctl.ref_route = REF_PIN;
         default: nxt_ctl.ref_route = REF_AMP;
      endcase
      nxt_ctl.ref_pin_on = (refsel == 2'h1);
      nxt_ctl.amp_enable = refctl_ff[AMP_EN_BIT];
      nxt_ctl.amp_from_bandgap = refctl_ff[AMP_IN_BIT];
      nxt_ctl.amp_ref_pin_on = ~refctl_ff[AMP_IN_BIT];
      nxt_ctl.amp_gain = refctl_ff[1:0];
      nxt_ctl.bandgap_enable = bg_ff[BG_EN_BIT];
   end

   // Registered analog controls
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ctl_ff <= '0;
         chan_ff <= 4'h0;
      end else begin
         ctl_ff <= nxt_ctl;
         chan_ff <= nxt_ctl.ext_channel_on ? external_channel_sel_in : 4'h0;
      end
   end

   assign analog_ctl_out = ctl_ff;
   assign external_channel_sel_out = chan_ff;
   assign rdata_out = rdata_ff;

   conv_clock_divider u_div (
      .mclk_in(mclk_in),
      .nrst_in(nrst_in),
      .div_sel_in(sel_ff[2:0]),
      .conv_clk_out(conv_clk_out)
   );
endmodule : adc_source_reference_select

// [design/adc_ctrl_pkg.sv]
package adc_ctrl_pkg;
   // Register offsets on the control port
   localparam logic [1:0] ADC_INPUT_AND_CLOCK_SELECT_OFS = 2'h0;
   localparam logic [1:0] ADC_REFERENCE_AND_AMP_CONTROL_OFS = 2'h1;
   localparam logic [1:0] BANDGAP_CONTROL_OFS = 2'h2;
   // Field positions
   localparam int SRC_LSB = 4;
   localparam int AMP_EN_BIT = 7;
   localparam int AMP_IN_BIT = 4;
   localparam int REF_LSB = 2;
   localparam int BG_EN_BIT = 0;
   // Implemented bit masks and reset values
   localparam logic [7:0] SEL_MASK = 8'hf7;
   localparam logic [7:0] REFCTL_MASK = 8'h9f;
   localparam logic [7:0] BG_MASK = 8'h01;
   localparam logic [7:0] REG_RESET = 8'h00;

   // Converter input routing
   typedef enum logic [2:0] {
      IN_EXTERNAL = 3'b000,
      IN_SUPPLY = 3'b001,
      IN_AMP = 3'b010,
      IN_GROUND = 3'b011
   } input_route_t;

   typedef enum logic [1:0] {
      REF_SUPPLY = 2'b00,
      REF_PIN = 2'b01,
      REF_AMP = 2'b10
   } ref_route_t;

   // Analog switch controls
   typedef struct packed {
      input_route_t route;
      logic [1:0] fraction;   // 0 full, 1 half, 2 quarter
      logic ext_channel_on;
      ref_route_t ref_route;
      logic ref_pin_on;
      logic amp_enable;
      logic amp_from_bandgap;
      logic amp_ref_pin_on;
      logic [1:0] amp_gain;
      logic bandgap_enable;
   } analog_ctl_t;
endpackage : adc_ctrl_pkg

// [design/conv_clock_divider.sv]
`timescale 1ns/1ps
module conv_clock_divider (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic nrst_in,
   // Divide select
   input wire logic [2:0] div_sel_in,
   // Divided clock
   output logic conv_clk_out
);
   logic [6:0] cnt_ff;
   logic clk_ff;

   // Free counter; bit n toggles at sys/2^(n+1)
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cnt_ff <= 7'h00;
      end else begin
         cnt_ff <= cnt_ff + 7'h01;
      end
   end

   // Divide by one passes clock straight; others tap counter
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         clk_ff <= 1'b0;
      end else begin
         clk_ff <= (div_sel_in == 3'h0) ? 1'b0 : cnt_ff[div_sel_in - 3'h1];
      end
   end

   assign conv_clk_out = (div_sel_in == 3'h0) ? mclk_in : clk_ff;
endmodule : conv_clock_divider

// [verification/adc_sel_chk.sv]
`timescale 1ns/1ps
module adc_sel_chk
   import adc_ctrl_pkg::*;
(
   // Watched ports
   input wire logic mclk_in,
   input wire logic nrst_in,
   input wire logic [1:0] addr_in,
   input wire logic rd_in,
   input wire logic [7:0] rdata_out,
   input wire adc_ctrl_pkg::analog_ctl_t analog_ctl_out,
   input wire logic [3:0] external_channel_sel_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!nrst_in);
   logic rv_ff;
   logic [1:0] ra_ff;
   logic [7:0] s;
   analog_ctl_t c;
   assign s = rdata_out;
   assign c = analog_ctl_out;
   // Remember which register the read data belong to
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rv_ff <= 1'b0;
         ra_ff <= 2'h0;
      end else begin
         rv_ff <= rd_in;
         ra_ff <= addr_in;
      end
   end
   // Read data and controls both come from the same register state
   a_ext_route: assert property (rv_ff && ra_ff == 2'h0 &&
      (&s[7:6] || s[5:4] == 2'h0 && !s[7]) |-> c.route == IN_EXTERNAL) else $error("ext route");
   a_int_route: assert property (rv_ff && ra_ff == 2'h0 && !s[7] && s[5:4] != 2'h0 |->
      c.route == (s[6] ? IN_AMP : IN_SUPPLY) && c.fraction == s[5:4] - 2'h1) else $error("int");
   a_gnd_route: assert property (rv_ff && ra_ff == 2'h0 && s[7:6] == 2'h2 |->
      c.route == IN_GROUND) else $error("ground route");
   a_ext_forced_off: assert property (c.route != IN_EXTERNAL |->
      !c.ext_channel_on && external_channel_sel_out == 4'h0) else $error("ext not off");
   a_unused_read_zero: assert property (rv_ff |->
      (ra_ff[1] ? s[7:1] == 7'h0 : ra_ff[0] ? s[6:5] == 2'h0 : !s[3])) else $error("unused");
   a_amp_ctl_match: assert property (rv_ff && ra_ff == 2'h1 |->
      c.amp_enable == s[7] && c.amp_from_bandgap == s[4] && c.amp_ref_pin_on == !s[4] &&
      c.amp_gain == s[1:0]) else $error("amp ctl");
   a_ref_route: assert property (rv_ff && ra_ff == 2'h1 |->
      c.ref_route == (s[3] ? REF_AMP : s[2] ? REF_PIN : REF_SUPPLY) &&
      c.ref_pin_on == (s[3:2] == 2'h1)) else $error("ref route");
   a_bg_enable: assert property (rv_ff && ra_ff == 2'h2 |->
      c.bandgap_enable == s[0]) else $error("bandgap");
endmodule : adc_sel_chk

bind adc_source_reference_select adc_sel_chk chk (.mclk_in(mclk_in), .nrst_in(nrst_in),
   .addr_in(addr_in), .rd_in(rd_in), .rdata_out(rdata_out), .analog_ctl_out(analog_ctl_out),
   .external_channel_sel_out(external_channel_sel_out));

// [verification/tb.sv]
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("unexpected %s exp %h got %h", n, e, g); end end
module tb;
   import adc_ctrl_pkg::*;
   logic mclk_in = 0, nrst_in = 0, wr_in = 0, rd_in = 0, rv_ff = 0;
   logic [1:0] addr_in = 0;
   logic [3:0] ch_in = 0, ch_v, ext_sel;
   logic conv_clk;
   realtime t0;
   logic [7:0] wdata_in = 0, rdata_out, exp_v;
   logic [7:0] regs[4] = '{default: 8'h0};
   logic [7:0] exp_q[$];
   int error_cnt = 0, n_checks = 0;
   analog_ctl_t ctl;
   always #4 mclk_in = ~mclk_in;
   adc_source_reference_select dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .external_channel_sel_in(ch_in), .analog_ctl_out(ctl),
      .external_channel_sel_out(ext_sel), .conv_clk_out(conv_clk));
   // One bus cycle; a read notes the byte it should return
   task automatic op(input logic w, input logic [1:0] a, input logic [7:0] d);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= w;
      rd_in <= !w;
      if (!w) exp_q.push_back(regs[a]);
      else if (a != 2'h3) regs[a] = d & (a == 2'h0 ? SEL_MASK : a == 2'h1 ? REFCTL_MASK : BG_MASK);
      @(posedge mclk_in);
   endtask : op
   // Drop strobes and close a test
   task automatic idle(input string n);
      wr_in <= 1'b0;
      rd_in <= 1'b0;
      repeat (3) @(posedge mclk_in);
      $display("test %s done", n);
   endtask : idle
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop
   // Compare each read result with the oldest note
   always @(posedge mclk_in) begin
      if (rv_ff) begin
         exp_v = exp_q.pop_front();
         `CHK("rdata", exp_v, rdata_out)
      end
      rv_ff <= rd_in && nrst_in;
   end
   // Reset values, then every source and reference code with random other bits
   initial begin
      void'($urandom(1061));
      repeat (5) @(posedge mclk_in);
      nrst_in <= 1'b1;
      for (int a = 0; a < 4; a++) op(1'b0, 2'(a), 8'h0);
      idle("reset");
      for (int i = 0; i < 16; i++) begin
         ch_v = 4'($urandom);
         ch_in <= ch_v;
         op(1'b1, 2'h0, {i[3:0], 4'($urandom)});
         op(1'b1, 2'h1, 8'($urandom) & 8'hf3 | {4'h0, i[1:0], 2'h0});
         op(1'b1, 2'h2, 8'($urandom));
         op(1'b1, 2'h3, 8'($urandom));
         for (int a = 0; a < 4; a++) op(1'b0, 2'(a), 8'h0);
         `CHK("ext_sel", ((i % 4 == 0 && i < 8) || i >= 12) ? ch_v : 4'h0, ext_sel)
      end
      idle("codes");
      // Bandgap on and settled before the amplifier takes it
      op(1'b1, 2'h2, 8'h01);
      idle("bandgap");
      // Amplifier as reference; no shared reference pin in use
      op(1'b1, 2'h1, 8'h98);
      idle("amp");
      `CHK("bg_amp", 3'h7, {ctl.amp_enable, ctl.amp_from_bandgap, ctl.bandgap_enable})
      // Conversion clock period for every divide code
      for (int k = 0; k < 8; k++) begin
         op(1'b1, 2'h0, {5'h00, 3'(k)});
         idle("div");
         repeat (2) @(posedge conv_clk);
         t0 = $realtime;
         @(posedge conv_clk);
         `CHK("div_period", 32'(1 << k), 32'(int'(($realtime - t0) / 8.0)))
      end
      report_and_stop();
   end
   // Under 1000 cycles of traffic; four times that means a hang
   initial begin
      #32000;
      error_cnt++;
      report_and_stop();
   end
endmodule : tb
